// file: verilog/npoc_consts.vh
/*
  Constants for the preset select and over-range pin control block:
  register indices, field positions, reset values and timing counts.
  Assumes inclusion by the block's single design file.
*/
`ifndef NPOC_CONSTS_VH
`define NPOC_CONSTS_VH

// printed offsets are not multiples of four: kept as indices, byte address = 4 * index
`define NPOC_IDX_OVERRANGE_OUTPUT_CONFIG 12'h213
`define NPOC_IDX_MODE 12'h214
`define NPOC_IDX_SEL 12'h215
`define NPOC_IDX_BIND 12'h216
`define NPOC_IDX_STATUS 12'h218

`define NPOC_RST_OVERRANGE_OUTPUT_CONFIG 8'h07
`define NPOC_RST_MODE 8'h00
`define NPOC_RST_SEL 8'h00
`define NPOC_RST_BIND 8'h02

`define NPOC_OVERRANGE_PIN_ENABLE_BIT 3
`define NPOC_EXP_MSB 2
`define NPOC_EXP_LSB 0
`define NPOC_SELA_MSB 1
`define NPOC_SELA_LSB 0
`define NPOC_SELB_MSB 3
`define NPOC_SELB_LSB 2

`define NPOC_MODE_REG 2'h0
`define NPOC_MODE_PINS_AB 2'h1
`define NPOC_MODE_PINS_A 2'h2

// stretch base: 8 device clock cycles, shifted by the exponent
`define NPOC_STRETCH_BASE 11'h008
`define NPOC_CNT_W 11

`define NPOC_UNMAPPED_DATA 32'h00000000

`endif

// file: verilog/npoc_ctrl.v
/*
  Preset selection and over-range pin control, with its Avalon-MM
  register slave. Assumes one clock, synchronous active-low reset,
  and preset pins and raw over-range flags synchronous to clk.
*/
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "npoc_consts.vh"

// Summary of operation
// - enable bit drives flags, else held low
// - enable gates only pins, not link bits
// - pulse at least 8 shl exponent cycles
// - four presets per channel, index chosen
// - single channel uses channel A method
// - mode 0: indices from register fields
// - mode 1: A pins and B pins
// - mode 2: A pins both; 3 reserved
// - B field bits 3:2, ignored single
// - A field bits 1:0 selects preset
// - single channel: A field sets frequency
module npoc_ctrl #(
  parameter ADDR_W = 14
)(
  input wire clk,
  input wire resetn,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire single_channel_mode,
  input wire [1:0] chan_a_preset_pins,
  input wire [1:0] chan_b_preset_pins,
  input wire [3:0] overrange_raw,
  input wire [3:0] link_overrange_raw,
  output wire [3:0] link_overrange_bits,
  output wire chan_a_flag0_out,
  output wire chan_a_flag1_out,
  output wire chan_b_flag0_out,
  output wire chan_b_flag1_out,
  output reg [1:0] chan_a_preset_index,
  output reg [1:0] chan_b_preset_index
);

  reg [7:0] overrange_output_config;
  reg [7:0] preset_source_mode;
  reg [7:0] preset_index_select;
  reg [7:0] channel_binding;
  reg [31:0] rdata;
  reg [31:0] next_rdata;
  reg ack;
  reg [3:0] flag_q;
  reg [`NPOC_CNT_W-1:0] hold_cnt [0:3];
  reg [1:0] next_a;
  reg [1:0] next_b;
  reg [`NPOC_CNT_W-1:0] stretch_len;

  wire [11:0] idx = avs_address[ADDR_W-1:2];
  // writes land on the edge where waitrequest is seen low, as the master expects
  wire wr_go = avs_write & ack;
  wire rd_go = avs_read & ~ack;
  wire overrange_pin_enable = overrange_output_config[`NPOC_OVERRANGE_PIN_ENABLE_BIT];
  wire [2:0] pulse_stretch_exponent = overrange_output_config[`NPOC_EXP_MSB:`NPOC_EXP_LSB];
  wire [1:0] preset_select_mode = preset_source_mode[1:0];

  // merge the low byte lane of a write into an 8-bit register
  function [7:0] lane0;
    input [7:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      lane0 = be[0] ? wd[7:0] : old;
    end
  endfunction

  // true when the word index addresses the given register
  function hit_idx;
    input [11:0] at;
    input [11:0] reg_idx;
    begin
      hit_idx = (at == reg_idx);
    end
  endfunction

  // one write strobe per register, each only on the answering edge
  wire wr_cfg = wr_go & hit_idx(idx, `NPOC_IDX_OVERRANGE_OUTPUT_CONFIG);
  wire wr_mode = wr_go & hit_idx(idx, `NPOC_IDX_MODE);
  wire wr_sel = wr_go & hit_idx(idx, `NPOC_IDX_SEL);
  wire wr_bind = wr_go & hit_idx(idx, `NPOC_IDX_BIND);
  // flags before gating, so software sees hits even with the pins off
  wire [7:0] status_word = {flag_q, chan_b_preset_index, chan_a_preset_index};

  // one wait state: the request is answered on the edge where ack is high
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign avs_readdata = rdata;

  always @(posedge clk)
  begin
    if (!resetn)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  // read word loaded one edge early so it stands when waitrequest drops
  always @*
  begin
    next_rdata = rdata;
    if (rd_go)
    begin
      if (hit_idx(idx, `NPOC_IDX_OVERRANGE_OUTPUT_CONFIG))
        next_rdata = {24'h000000, overrange_output_config};
      else if (hit_idx(idx, `NPOC_IDX_MODE))
        next_rdata = {24'h000000, preset_source_mode};
      else if (hit_idx(idx, `NPOC_IDX_SEL))
        next_rdata = {24'h000000, preset_index_select};
      else if (hit_idx(idx, `NPOC_IDX_BIND))
        next_rdata = {24'h000000, channel_binding};
      else if (hit_idx(idx, `NPOC_IDX_STATUS))
        next_rdata = {24'h000000, status_word};
      else
        next_rdata = `NPOC_UNMAPPED_DATA;
    end
  end

  always @(posedge clk)
  begin
    if (!resetn)
      rdata <= 32'h00000000;
    else
      rdata <= next_rdata;
  end

  // reserved bits are stored and read back as written
  always @(posedge clk)
  begin
    if (!resetn)
      overrange_output_config <= `NPOC_RST_OVERRANGE_OUTPUT_CONFIG;
    else if (wr_cfg)
      overrange_output_config <= lane0(overrange_output_config, avs_writedata, avs_byteenable);
  end

  always @(posedge clk)
  begin
    if (!resetn)
      preset_source_mode <= `NPOC_RST_MODE;
    else if (wr_mode)
      preset_source_mode <= lane0(preset_source_mode, avs_writedata, avs_byteenable);
  end

  always @(posedge clk)
  begin
    if (!resetn)
      preset_index_select <= `NPOC_RST_SEL;
    else if (wr_sel)
      preset_index_select <= lane0(preset_index_select, avs_writedata, avs_byteenable);
  end

  always @(posedge clk)
  begin
    if (!resetn)
      channel_binding <= `NPOC_RST_BIND;
    else if (wr_bind)
      channel_binding <= lane0(channel_binding, avs_writedata, avs_byteenable);
  end

  // channel A index source
  always @*
  begin
    next_a = chan_a_preset_index;
    case (preset_select_mode)
      `NPOC_MODE_REG:
      begin
        next_a = preset_index_select[`NPOC_SELA_MSB:`NPOC_SELA_LSB];
      end
      `NPOC_MODE_PINS_AB:
      begin
        next_a = chan_a_preset_pins;
      end
      `NPOC_MODE_PINS_A:
      begin
        next_a = chan_a_preset_pins;
      end
      // reserved mode: keep current selection rather than guess
      default:
      begin
        next_a = chan_a_preset_index;
      end
    endcase
  end

  // channel B index source; single channel borrows A's choice
  always @*
  begin
    next_b = chan_b_preset_index;
    case (preset_select_mode)
      `NPOC_MODE_REG:
      begin
        next_b = preset_index_select[`NPOC_SELB_MSB:`NPOC_SELB_LSB];
      end
      `NPOC_MODE_PINS_AB:
      begin
        next_b = chan_b_preset_pins;
      end
      `NPOC_MODE_PINS_A:
      begin
        next_b = chan_a_preset_pins;
      end
      default:
      begin
        next_b = chan_b_preset_index;
      end
    endcase
    if (single_channel_mode)
      next_b = next_a;
  end

  always @(posedge clk)
  begin
    if (!resetn)
      chan_a_preset_index <= 2'h0;
    else
      chan_a_preset_index <= next_a;
  end

  // channel B kept apart so its source can differ from A
  always @(posedge clk)
  begin
    if (!resetn)
      chan_b_preset_index <= 2'h0;
    else
      chan_b_preset_index <= next_b;
  end

  // minimum pulse length in device clock cycles for an exponent
  function [`NPOC_CNT_W-1:0] stretch_cycles;
    input [2:0] exp_val;
    begin
      stretch_cycles = `NPOC_STRETCH_BASE << exp_val;
    end
  endfunction

  always @*
  begin
    stretch_len = stretch_cycles(pulse_stretch_exponent);
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_flag
      // counter still running: pulse not yet at its minimum length
      wire busy = hold_cnt[g] != {`NPOC_CNT_W{1'b0}};

      always @(posedge clk)
      begin
        if (!resetn)
        begin
          hold_cnt[g] <= {`NPOC_CNT_W{1'b0}};
          flag_q[g] <= 1'b0;
        end
        else if (overrange_raw[g])
        begin
          hold_cnt[g] <= stretch_len - 11'h001;
          flag_q[g] <= 1'b1;
        end
        else if (busy)
        begin
          hold_cnt[g] <= hold_cnt[g] - 11'h001;
          flag_q[g] <= 1'b1;
        end
        else
          flag_q[g] <= 1'b0;
      end
    end
  endgenerate

  assign chan_a_flag0_out = flag_q[0] & overrange_pin_enable;
  assign chan_a_flag1_out = flag_q[1] & overrange_pin_enable;
  assign chan_b_flag0_out = flag_q[2] & overrange_pin_enable;
  assign chan_b_flag1_out = flag_q[3] & overrange_pin_enable;
  assign link_overrange_bits = link_overrange_raw;

endmodule

// file: testbench/npoc_props.sv
/* port assertions for npoc_ctrl.
   bound into every npoc_ctrl, one clock domain. */
`timescale 1ns/100ps
module npoc_props (
  input wire clk,
  input wire resetn,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire single_channel_mode,
  input wire [1:0] chan_a_preset_pins,
  input wire [3:0] overrange_raw,
  input wire [3:0] link_overrange_raw,
  input wire [3:0] link_overrange_bits,
  input wire chan_a_flag0_out,
  input wire [1:0] chan_a_preset_index,
  input wire [1:0] chan_b_preset_index
);
  reg [10:0] quiet;
  wire req = avs_read | avs_write;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // cycles since the last raw hit on overrange_raw bit 0, saturating
  always @(posedge clk)
    quiet <= (!resetn) ? 11'h7FF : overrange_raw[0] ? 11'h000 : quiet + {10'h000, quiet != 11'h7FF};
  a_reset_idx: assert property ($past(!resetn) |-> {chan_a_preset_index, chan_b_preset_index} == 4'h0)
    else $error("index not cleared");
  a_link_pass: assert property (link_overrange_bits == link_overrange_raw)
    else $error("link bits gated");
  a_single_copy: assert property ($past(single_channel_mode) |-> chan_b_preset_index == chan_a_preset_index)
    else $error("single index differs");
  a_wait_one: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bad wait state");
  a_idle_ready: assert property (!req |-> !avs_waitrequest)
    else $error("wait while idle");
  a_rd_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_flag_min: assert property ($fell(chan_a_flag0_out) && !$past(avs_write) |-> quiet >= 11'h008)
    else $error("flag pulse short");
  a_idx_cause: assert property ($changed(chan_a_preset_index) |-> $past(avs_write) || $past(avs_write, 2)
    || $past(chan_a_preset_pins) != $past(chan_a_preset_pins, 2))
    else $error("index moved alone");
  cover property ($rose(chan_a_flag0_out));
  cover property (single_channel_mode && chan_b_preset_index != 2'h0);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind npoc_ctrl npoc_props npoc_props_i (.clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .single_channel_mode(single_channel_mode),
  .chan_a_preset_pins(chan_a_preset_pins), .overrange_raw(overrange_raw), .link_overrange_raw(link_overrange_raw),
  .link_overrange_bits(link_overrange_bits), .chan_a_flag0_out(chan_a_flag0_out),
  .chan_a_preset_index(chan_a_preset_index), .chan_b_preset_index(chan_b_preset_index));

// file: testbench/npoc_host.sv
/* host model: preset pins and raw hits.
   changes only right after rising clk edges. */
`timescale 1ns/100ps
module npoc_host (
  input wire clk,
  output reg [1:0] chan_a_preset_pins,
  output reg [1:0] chan_b_preset_pins,
  output reg [3:0] overrange_raw
);
  initial
  begin
    chan_a_preset_pins = 2'h0;
    chan_b_preset_pins = 2'h0;
    overrange_raw = 4'h0;
  end
  task set_pins(input logic [1:0] a, input logic [1:0] b);
    chan_a_preset_pins <= a;
    chan_b_preset_pins <= b;
  endtask
  task hit;
    overrange_raw <= 4'hF;
    @(posedge clk);
    overrange_raw <= 4'h0;
  endtask
endmodule

// file: testbench/npoc_ctrl_tb.sv
/* bench for npoc_ctrl: bus driver, host model, queue checker.
   assumes nothing of the slave's latency; every wait is bounded. */
`timescale 1ns/100ps
`include "npoc_consts.vh"
module npoc_ctrl_tb;
  logic clk = 0, resetn = 0, avs_read = 0, avs_write = 0, sc = 0, chk = 0;
  logic [13:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, r = 32'hBBDE4D4E;
  logic [3:0] lraw = 0, raw, lob;
  logic [1:0] pa, pb, ia, ib;
  logic avs_waitrequest, fa0, fa1, fb0, fb1;
  logic [7:0] q[$], e;
  int err_count = 0, check_count = 0, n, m, i;
  always #5 clk = ~clk;
  npoc_host npoc_host_i (.clk(clk), .chan_a_preset_pins(pa), .chan_b_preset_pins(pb), .overrange_raw(raw));
  npoc_ctrl npoc_ctrl_i (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .single_channel_mode(sc), .chan_a_preset_pins(pa),
    .chan_b_preset_pins(pb), .overrange_raw(raw), .link_overrange_raw(lraw), .link_overrange_bits(lob),
    .chan_a_flag0_out(fa0), .chan_a_flag1_out(fa1), .chan_b_flag0_out(fb0), .chan_b_flag1_out(fb1),
    .chan_a_preset_index(ia), .chan_b_preset_index(ib));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
    if (chk || (avs_read && avs_waitrequest === 1'b0))
      check(chk ? "flags and indices" : "read data", chk ? {fb1, fb0, fa1, fa0, ib, ia} : avs_readdata[7:0], q.pop_front());
  always @(posedge clk)
    if (chk)
      check("link bits", {4'h0, lob}, {4'h0, lraw});
  task bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
    n = 0;
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    if (avs_waitrequest !== 1'b0)
    begin
      err_count++;
      report_and_stop;
    end
    else
    begin
      avs_read <= 0;
      avs_write <= 0;
      @(posedge clk);
    end
  endtask
  task look(input logic [7:0] x);
    q.push_back(x);
    chk <= 1;
    @(posedge clk);
    chk <= 0;
    @(posedge clk);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    for (i = 0; i < 5; i++)
    begin
      q.push_back(i == 0 ? 8'h07 : i == 3 ? 8'h02 : 8'h00);
      bus(0, i == 4 ? 12'h300 : `NPOC_IDX_OVERRANGE_OUTPUT_CONFIG + i[11:0], 8'h00);
    end
    for (m = 0; m < 4; m++)
      for (i = 0; i < 3; i++)
      begin
        repeat (8) r = lfsr(r);
        npoc_host_i.set_pins(r[1:0], r[3:2]);
        lraw <= r[7:4];
        sc <= m == 3;
        bus(1, `NPOC_IDX_MODE, m == 3 ? 8'h00 : m[7:0]);
        bus(1, `NPOC_IDX_SEL, r[15:8]);
        e = m == 1 ? r[3:0] : m == 2 ? {r[1:0], r[1:0]} : m == 3 ? {r[9:8], r[9:8]} : r[11:8];
        look(e);
      end
    sc <= 0;
    e = {4'h0, r[11:8]};
    for (i = 0; i < 3; i++)
    begin
      bus(1, `NPOC_IDX_OVERRANGE_OUTPUT_CONFIG, i == 2 ? 8'h00 : {7'h04, i[0]});
      npoc_host_i.hit();
      repeat (i == 2 ? 2 : (8 << i) - 1) @(posedge clk);
      look(i == 2 ? e : {4'hF, e[3:0]});
      look(e);
    end
    report_and_stop;
  end
endmodule
